// ### epwm_act_delay.sv
// delays each rising edge of a pwm level by a count of instruction cycles
// assumes the count is stable while an edge is pending
`include "epwm_map.svh"

module epwm_act_delay (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // waveform
  input  wire logic       pwm_in,
  input  wire logic [6:0] delay_count,
  output logic            pwm_delayed
);

  epwm_pkg::dly_state_t st_ff;
  epwm_pkg::dly_state_t nxt_st;
  logic                 rise;

  assign rise        = pwm_in & ~st_ff.prev;
  assign pwm_delayed = st_ff.q;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = pwm_in;
    if (!pwm_in) begin
      // falling edges pass at once, only the active edge is held back
      nxt_st.q    = 1'b0; // R20
      nxt_st.pend = 1'b0;
    end else if (rise) begin
      if (delay_count == 7'h00) begin
        nxt_st.q = 1'b1;
      end else begin
        nxt_st.pend = 1'b1; // R12
        nxt_st.cnt  = 9'({delay_count, 2'b00} - 9'h001);
      end
    end else if (st_ff.pend) begin
      if (st_ff.cnt == 9'h000) begin
        nxt_st.q    = 1'b1;
        nxt_st.pend = 1'b0;
      end else begin
        nxt_st.cnt = st_ff.cnt - 9'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  fall_immediate_a: assert property ($fell(pwm_in) |=> !pwm_delayed) // R20
    else $error("delayed output did not follow a falling edge");
  one_insn_hold_a: assert property ((rise && delay_count == 7'h01) |=> !pwm_delayed[*4]) // R12
    else $error("active edge came before one instruction cycle");
  one_insn_rise_a: assert property ((rise && delay_count == 7'h01) ##1 // R12
      (pwm_in && delay_count == 7'h01)[*4] |=> pwm_delayed)
    else $error("active edge late after one instruction cycle");
  delayed_edge_c: cover property (rise && delay_count != 7'h00);

endmodule

// ### epwm_comp_sync.sv
// holds comparator outputs on the timer1 tick when their sync option is on
// assumes t1_tick is a one-cycle enable in the hclk domain
module epwm_comp_sync (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // comparators
  input  wire logic cmp1_out,
  input  wire logic cmp2_out,
  input  wire logic cmp1_sync_en,
  input  wire logic cmp2_sync_en,
  input  wire logic t1_tick,
  output logic      cmp1_eff,
  output logic      cmp2_eff
);

  epwm_pkg::csync_state_t st_ff;
  epwm_pkg::csync_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (t1_tick) begin
      nxt_st.c1_held = cmp1_out; // R9
      nxt_st.c2_held = cmp2_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cmp1_eff = cmp1_sync_en ? st_ff.c1_held : cmp1_out;
  assign cmp2_eff = cmp2_sync_en ? st_ff.c2_held : cmp2_out;

  held_between_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
      (cmp1_sync_en && !t1_tick) ##1 cmp1_sync_en |-> $stable(cmp1_eff))
    else $error("synced comparator changed between timer1 ticks");

endmodule

// ### epwm_far_model.sv
// far side of the pwm channel: three timer time bases and the timer1 tick
// assumes one clock domain shared with the channel, timers restart with reset
module epwm_far_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // timers
  output logic      [2:0] tb_period_start,
  output logic      [2:0] tb_pwm_level,
  output logic            t1_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // time bases
  // ****************
  // periods differ so a wrong time-base choice shows up; level is high in the first half
  localparam logic [7:0] PER [3] = '{8'h40, 8'h30, 8'h50};
  logic [7:0] cnt_ff [3];
  logic [4:0] tick_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= '{default: 8'h00};
      tick_ff <= 5'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= (cnt_ff[i] == PER[i] - 8'h01) ? 8'h00 : cnt_ff[i] + 8'h01;
      end
      tick_ff <= (tick_ff == 5'h13) ? 5'h00 : tick_ff + 5'h01;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tb_period_start[i] = hresetn && (cnt_ff[i] == 8'h00);
      tb_pwm_level[i]    = cnt_ff[i] < (PER[i] >> 1);
    end
    t1_tick = hresetn && (tick_ff == 5'h00);
  end
endmodule

// ### epwm_map.svh
// register map, field positions, reset values and timing counts of the enhanced pwm
// assumes a 32-bit ahb-lite slave, one word per register
`ifndef EPWM_MAP_SVH
`define EPWM_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_TMRSEL   8'h00
`define OFS_ASD      8'h04
`define OFS_PWMCON   8'h08
`define OFS_STEER    8'h0c
`define OFS_CHCTRL   8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define TB_CH1_LSB   0
`define TB_CH2_LSB   2
`define TB_CH3_LSB   4
`define TB_CH4_LSB   6
`define ASD_STAT_BIT 7
`define ASD_SEL_LSB  4
`define ASD_AC_LSB   2
`define ASD_BD_LSB   0
`define RSEN_BIT     7
`define SYNC_BIT     4
`define OCFG_LSB     6

// ****************************************************************
// reset values
// ****************************************************************
`define RST_TMRSEL   8'h00
`define RST_STEER    5'h01
`define RST_MODE     4'h0

// ****************************************************************
// timing: one instruction cycle is four oscillator periods
// ****************************************************************
`define CLK_NS       8
`define INSN_NS      32
`define INSN_CLKS    (`INSN_NS / `CLK_NS)

`endif

// ### epwm_pkg.sv
// types shared by the enhanced pwm modules
// assumes epwm_map.svh supplies all numbers
package epwm_pkg;

  typedef enum logic [1:0] {
    CFG_SINGLE,
    CFG_FULL_FWD,
    CFG_HALF,
    CFG_FULL_REV
  } ocfg_t;

  typedef struct packed {
    logic [8:0] cnt;
    logic       pend;
    logic       prev;
    logic       q;
  } dly_state_t;

  typedef struct packed {
    logic c1_held;
    logic c2_held;
  } csync_state_t;

  typedef struct packed {
    logic [7:0]  tmrsel;
    logic        asd_status;
    logic [2:0]  asd_sel;
    logic [1:0]  pss_ac;
    logic [1:0]  pss_bd;
    logic        rsen;
    logic [6:0]  dcount;
    logic [4:0]  steer;
    logic [3:0]  steer_act;
    logic [3:0]  mode;
    ocfg_t       ocfg;
    logic [1:0]  div;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
  } top_state_t;

endpackage

// ### epwm_top.sv
// enhanced pwm channel: time base choice, auto-shutdown, restart, delay, steering
// assumes pwm levels and period pulses per time base come from the timers
//
// Function
// [R1] two-bit field picks time base 00/01/10
// [R2] four select fields at bits 7-6..1-0
// [R3] status bit set means outputs in shutdown
// [R4] source select 000 disables auto-shutdown
// [R5] 001/010/011 pick comparator one, two, either
// [R6] 100 fault pin low; 101-111 add comparators
// [R7] shutdown a/c: 1x float, 01 high, 00 low
// [R8] shutdown b/d: 1x float, 01 high, 00 low
// [R9] synced comparators act after timer1 sync
// [R10] restart enable clears status when source gone
// [R11] otherwise software clears status to resume
// [R12] delay active edge by count instruction cycles
// [R13] steering change at period or instruction boundary
// [R14] steer bits route pwm to pins a-d
// [R15] steering bits 7-5 zero, resets to pin a
// [R16] steering only in pwm single-output mode
// [R17] mode low bits set a/c and b/d polarity
// [R18] output config: single, forward, half, reverse
// [R19] status set at once, holds shutdown
// [R20] delay only inactive-to-active edges
//
// Design decisions made here: the address map and the AHB-Lite register port.
`include "epwm_map.svh"

module epwm_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // time bases
  input  wire logic [2:0]  tb_period_start,
  input  wire logic [2:0]  tb_pwm_level,
  output logic [1:0]       chan1_timebase_sel,
  output logic [1:0]       chan2_timebase_sel,
  output logic [1:0]       chan3_timebase_sel,
  output logic [1:0]       chan4_timebase_sel,
  // shutdown sources
  input  wire logic        cmp1_out,
  input  wire logic        cmp2_out,
  input  wire logic        cmp1_sync_en,
  input  wire logic        cmp2_sync_en,
  input  wire logic        t1_tick,
  input  wire logic        fault_input_pin_n,
  // output pins
  output logic             pwm_out_a,
  output logic             pwm_out_a_oe,
  output logic             pwm_out_b,
  output logic             pwm_out_b_oe,
  output logic             pwm_out_c,
  output logic             pwm_out_c_oe,
  output logic             pwm_out_d,
  output logic             pwm_out_d_oe
);

  // ****************************************************************
  // state and helpers
  // ****************************************************************
  epwm_pkg::top_state_t st_ff;
  epwm_pkg::top_state_t nxt_st;
  logic                 c1_eff;
  logic                 c2_eff;
  logic                 pwm_sel;
  logic                 per_sel;
  logic                 mod_p;
  logic                 mod_n;
  logic                 insn_en;
  logic                 hit;
  logic                 acc;
  logic                 in_pwm;

  function automatic logic src_hit(input logic [2:0] sel, input logic c1, input logic c2,
                                   input logic flt_n);
    return (sel[2] & ~flt_n) | (sel[0] & c1) | (sel[1] & c2);
  endfunction

  function automatic logic [31:0] read_word(input epwm_pkg::top_state_t s,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      `OFS_TMRSEL: w[7:0] = s.tmrsel;
      `OFS_ASD:    w[7:0] = {s.asd_status, s.asd_sel, s.pss_ac, s.pss_bd};
      `OFS_PWMCON: w[7:0] = {s.rsen, s.dcount};
      `OFS_STEER:  w[4:0] = s.steer; // R15
      `OFS_CHCTRL: w[7:0] = {s.ocfg, 2'b00, s.mode};
      default:     w = '0;
    endcase
    return w;
  endfunction

  // returns {oe, level}; shutdown levels ignore polarity
  function automatic logic [1:0] pin_drive(input logic val, input logic pol,
                                           input logic sd, input logic [1:0] pss);
    if (sd) begin
      return {~pss[1], pss[0]};
    end
    return {1'b1, val ^ pol};
  endfunction

  // ****************************************************************
  // time base and sources
  // ****************************************************************
  always_comb begin
    unique case (st_ff.tmrsel[`TB_CH1_LSB +: 2]) // R1
      2'b00: begin
        pwm_sel = tb_pwm_level[0];
        per_sel = tb_period_start[0];
      end
      2'b01: begin
        pwm_sel = tb_pwm_level[1];
        per_sel = tb_period_start[1];
      end
      2'b10: begin
        pwm_sel = tb_pwm_level[2];
        per_sel = tb_period_start[2];
      end
      default: begin
        // reserved code: no time base, pwm level and period pulse stay low
        pwm_sel = 1'b0;
        per_sel = 1'b0;
      end
    endcase
  end

  epwm_comp_sync u_sync (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .cmp1_out     (cmp1_out),
    .cmp2_out     (cmp2_out),
    .cmp1_sync_en (cmp1_sync_en),
    .cmp2_sync_en (cmp2_sync_en),
    .t1_tick      (t1_tick),
    .cmp1_eff     (c1_eff),
    .cmp2_eff     (c2_eff)
  );

  // dead band of the half bridge reuses the activation delay on both legs
  epwm_act_delay u_dly_p (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pwm_in      (pwm_sel),
    .delay_count (st_ff.dcount),
    .pwm_delayed (mod_p)
  );

  epwm_act_delay u_dly_n (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pwm_in      (~pwm_sel),
    .delay_count (st_ff.dcount),
    .pwm_delayed (mod_n)
  );

  assign hit     = src_hit(st_ff.asd_sel, c1_eff, c2_eff, fault_input_pin_n); // R4 R5 R6
  assign insn_en = st_ff.div == 2'(`INSN_CLKS - 1);
  assign acc     = hsel & hready & htrans[1];
  assign in_pwm  = st_ff.mode[3:2] == 2'b11;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [3:0] val;
    logic [3:0] use_pin;
    logic [1:0] drv;
    val     = '0;
    use_pin = '0;
    drv     = '0;
    nxt_st  = st_ff;
    nxt_st.div     = insn_en ? 2'b00 : st_ff.div + 2'b01;
    nxt_st.wr_pend = acc & hwrite;
    if (acc) begin
      nxt_st.wr_addr = haddr[7:0];
    end
    if (acc && !hwrite) begin
      nxt_st.hrdata = read_word(st_ff, haddr[7:0]);
    end
    if (st_ff.wr_pend) begin
      case (st_ff.wr_addr)
        `OFS_TMRSEL: nxt_st.tmrsel = hwdata[7:0]; // R2
        `OFS_ASD: begin
          nxt_st.asd_status = hwdata[`ASD_STAT_BIT]; // R11
          nxt_st.asd_sel    = hwdata[`ASD_SEL_LSB +: 3];
          nxt_st.pss_ac     = hwdata[`ASD_AC_LSB +: 2];
          nxt_st.pss_bd     = hwdata[`ASD_BD_LSB +: 2];
        end
        `OFS_PWMCON: begin
          nxt_st.rsen   = hwdata[`RSEN_BIT];
          nxt_st.dcount = hwdata[6:0];
        end
        `OFS_STEER:  nxt_st.steer = hwdata[4:0];
        `OFS_CHCTRL: begin
          nxt_st.ocfg = epwm_pkg::ocfg_t'(hwdata[`OCFG_LSB +: 2]);
          nxt_st.mode = hwdata[3:0];
        end
        default: ;
      endcase
    end
    // restart waits for a period boundary so no runt pulse leaves the bridge
    if (st_ff.rsen && per_sel && !hit) begin
      nxt_st.asd_status = 1'b0; // R10
    end
    // a live source beats any clear in the same cycle
    if (hit) begin
      nxt_st.asd_status = 1'b1; // R19 R3
    end
    if (st_ff.steer[`SYNC_BIT] ? per_sel : insn_en) begin
      nxt_st.steer_act = st_ff.steer[3:0]; // R13
    end
    unique case (st_ff.ocfg) // R18
      epwm_pkg::CFG_SINGLE: begin
        val     = {4{mod_p}};
        use_pin = st_ff.steer_act; // R14 R16
      end
      epwm_pkg::CFG_FULL_FWD: begin
        val     = {mod_p, 1'b0, 1'b0, 1'b1};
        use_pin = 4'hf;
      end
      epwm_pkg::CFG_HALF: begin
        val     = {1'b0, 1'b0, mod_n, mod_p};
        use_pin = 4'h3;
      end
      epwm_pkg::CFG_FULL_REV: begin
        val     = {1'b0, 1'b1, mod_p, 1'b0};
        use_pin = 4'hf;
      end
    endcase
    if (!in_pwm) begin
      use_pin = 4'h0;
    end
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) begin
        drv = pin_drive(val[i], st_ff.mode[1], nxt_st.asd_status, st_ff.pss_ac); // R7 R17
      end else begin
        drv = pin_drive(val[i], st_ff.mode[0], nxt_st.asd_status, st_ff.pss_bd); // R8 R17
      end
      nxt_st.pin_oe[i]  = use_pin[i] & drv[1];
      nxt_st.pin_out[i] = use_pin[i] & drv[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff        <= '0;
      st_ff.tmrsel <= `RST_TMRSEL;
      st_ff.steer  <= `RST_STEER; // R15
      st_ff.mode   <= `RST_MODE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = st_ff.hrdata;
  assign chan1_timebase_sel = st_ff.tmrsel[`TB_CH1_LSB +: 2];
  assign chan2_timebase_sel = st_ff.tmrsel[`TB_CH2_LSB +: 2];
  assign chan3_timebase_sel = st_ff.tmrsel[`TB_CH3_LSB +: 2];
  assign chan4_timebase_sel = st_ff.tmrsel[`TB_CH4_LSB +: 2];
  assign pwm_out_a          = st_ff.pin_out[0];
  assign pwm_out_b          = st_ff.pin_out[1];
  assign pwm_out_c          = st_ff.pin_out[2];
  assign pwm_out_d          = st_ff.pin_out[3];
  assign pwm_out_a_oe       = st_ff.pin_oe[0];
  assign pwm_out_b_oe       = st_ff.pin_oe[1];
  assign pwm_out_c_oe       = st_ff.pin_oe[2];
  assign pwm_out_d_oe       = st_ff.pin_oe[3];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  tb_pick_a: assert property (st_ff.tmrsel[1:0] == 2'b01 |-> pwm_sel == tb_pwm_level[1]) // R1
    else $error("time base select 01 did not pick the second timer");
  status_set_a: assert property (hit |=> st_ff.asd_status) // R19
    else $error("shutdown source did not set status next cycle");
  src_off_a: assert property ((st_ff.asd_sel == 3'b000 && !st_ff.wr_pend) // R4
      |=> !$rose(st_ff.asd_status))
    else $error("shutdown with sources disabled");
  cmp1_src_a: assert property ((st_ff.asd_sel == 3'b001 && c1_eff) |=> st_ff.asd_status) // R5
    else $error("comparator one did not shut down");
  fault_src_a: assert property ((st_ff.asd_sel == 3'b100 && !fault_input_pin_n) // R6
      |=> st_ff.asd_status)
    else $error("fault pin low did not shut down");
  shut_ac_a: assert property ((in_pwm && nxt_st.asd_status && st_ff.pss_ac == 2'b01 // R7
      && (st_ff.ocfg != epwm_pkg::CFG_SINGLE || st_ff.steer_act[0]))
      |=> pwm_out_a && pwm_out_a_oe)
    else $error("pin a not driven high in shutdown");
  shut_bd_a: assert property ((nxt_st.asd_status && st_ff.pss_bd[1]) // R8
      |=> !pwm_out_b_oe && !pwm_out_d_oe)
    else $error("pins b and d not floating in shutdown");
  restart_a: assert property ((st_ff.asd_status && st_ff.rsen && per_sel && !hit // R10
      && !st_ff.wr_pend) |=> !st_ff.asd_status)
    else $error("auto restart did not clear status");
  steer_sync_a: assert property ((st_ff.steer[`SYNC_BIT] && !per_sel) // R13
      |=> $stable(st_ff.steer_act))
    else $error("synced steering changed inside a period");
  steer_rsv_a: assert property ((acc && !hwrite && haddr[7:0] == `OFS_STEER) // R15
      |=> hrdata[31:5] == 27'h0000000)
    else $error("steering upper bits not zero");
  steer_pol_a: assert property ((in_pwm && st_ff.ocfg == epwm_pkg::CFG_SINGLE // R14 R17
      && !nxt_st.asd_status && st_ff.steer_act[0])
      |=> pwm_out_a_oe && pwm_out_a == ($past(mod_p) ^ $past(st_ff.mode[1])))
    else $error("steered pin a wrong level");
  half_pins_a: assert property ((in_pwm && st_ff.ocfg == epwm_pkg::CFG_HALF // R18
      && !nxt_st.asd_status) |=> !pwm_out_c_oe && !pwm_out_d_oe
      && pwm_out_b == ($past(mod_n) ^ $past(st_ff.mode[0])))
    else $error("half bridge pins wrong");
  tb_period_a: assert property (st_ff.tmrsel[1:0] != 2'b11 // R1
      |-> per_sel == tb_period_start[st_ff.tmrsel[1:0]])
    else $error("period pulse from the wrong time base");
  cmp2_src_a: assert property ((st_ff.asd_sel == 3'b010 && c2_eff) |=> st_ff.asd_status) // R5
    else $error("comparator two did not shut down");
  fault_or_a: assert property ((st_ff.asd_sel == 3'b111 && !fault_input_pin_n) // R6
      |=> st_ff.asd_status)
    else $error("fault pin low with comparators selected did not shut down");
  steer_insn_a: assert property ((!st_ff.steer[`SYNC_BIT] && insn_en) // R13
      |=> st_ff.steer_act == $past(st_ff.steer[3:0]))
    else $error("unsynced steering missed the instruction boundary");
  shut_low_a: assert property ((nxt_st.asd_status && st_ff.pss_ac == 2'b00) // R7
      |=> !pwm_out_a && !pwm_out_c)
    else $error("pins a and c not low in shutdown");

  shutdown_c: cover property ($rose(st_ff.asd_status));
  restart_c: cover property (st_ff.rsen && $fell(st_ff.asd_status));
  steer_c: cover property (in_pwm && $changed(st_ff.steer_act));
  half_bridge_c: cover property (in_pwm && st_ff.ocfg == epwm_pkg::CFG_HALF && mod_n);

endmodule

// ### tb_top.sv
// self-checking bench of the enhanced pwm channel
// assumes epwm_top answers ahb-lite with zero wait states and the far model drives the timers
`include "epwm_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // signals
  // ****************
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hreadyout, hresp;
  logic [31:0] hrdata, rv;
  logic [2:0]  tb_period_start, tb_pwm_level;
  logic [1:0]  chan1_timebase_sel, chan2_timebase_sel, chan3_timebase_sel, chan4_timebase_sel;
  logic        cmp1_out = 1'b0, cmp2_out = 1'b0, cmp1_sync_en = 1'b0, cmp2_sync_en = 1'b0;
  logic        t1_tick;
  logic        fault_input_pin_n = 1'b1;
  logic        pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe;
  logic        pwm_out_c, pwm_out_c_oe, pwm_out_d, pwm_out_d_oe;
  int          failures = 0, tests_run = 0, cycles = 0;
  wire  [3:0]  oe = {pwm_out_d_oe, pwm_out_c_oe, pwm_out_b_oe, pwm_out_a_oe};
  wire  [3:0]  pv = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  epwm_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .tb_period_start, .tb_pwm_level, .chan1_timebase_sel,
    .chan2_timebase_sel, .chan3_timebase_sel, .chan4_timebase_sel, .cmp1_out, .cmp2_out,
    .cmp1_sync_en, .cmp2_sync_en, .t1_tick, .fault_input_pin_n, .pwm_out_a, .pwm_out_a_oe,
    .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe, .pwm_out_d, .pwm_out_d_oe);
  epwm_far_model i_far (.hclk, .hresetn, .tb_period_start, .tb_pwm_level, .t1_tick);

  // ****************
  // helpers
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // every call starts right after a rising edge, as the bus master must
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d}, rv);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask
  task automatic pulse;
    do @(posedge hclk); while (tb_period_start[0] !== 1'b1);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rdc(`OFS_TMRSEL, 32'h0);
    rdc(`OFS_ASD, 32'h0);
    rdc(`OFS_PWMCON, 32'h0);
    rdc(`OFS_STEER, 32'h01);
    rdc(`OFS_CHCTRL, 32'h0);
    rdc(8'h14, 32'h0);
    wr(8'h14, 8'h55);
    rdc(8'h14, 32'h0);
    wr(`OFS_STEER, 8'hff);
    rdc(`OFS_STEER, 32'h1f);
    wr(`OFS_STEER, 8'h01);
    wr(`OFS_TMRSEL, 8'he5);
    rdc(`OFS_TMRSEL, 32'he5);
    chk({chan4_timebase_sel, chan3_timebase_sel, chan2_timebase_sel, chan1_timebase_sel},
        32'he5);
    chk(hresp, 32'h0);
    wr(`OFS_TMRSEL, 8'h00);
    $display("regs test done");
  endtask

  task automatic t_codes;
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 3; k++) begin
        s = i[2:0];
        wr(`OFS_ASD, {1'b0, s, 4'h0});
        {fault_input_pin_n, cmp2_out, cmp1_out} <= 3'b100 ^ (3'b001 << k);
        cyc(2);
        rdc(`OFS_ASD, {24'h0, s[k], s, 4'h0});
        {fault_input_pin_n, cmp2_out, cmp1_out} <= 3'b100;
        wr(`OFS_ASD, 8'h00);
      end
    end
    $display("source code test done");
  endtask

  task automatic t_sync;
    // held values are idle before sync goes on
    wr(`OFS_ASD, 8'h30);
    do @(posedge hclk); while (t1_tick !== 1'b1);
    {cmp1_sync_en, cmp2_sync_en} <= 2'b11;
    {cmp1_out, cmp2_out} <= 2'b11;
    cyc(4);
    rdc(`OFS_ASD, 32'h30);
    cyc(22);
    rdc(`OFS_ASD, 32'hb0);
    {cmp1_out, cmp2_out} <= 2'b00;
    cyc(22);
    wr(`OFS_ASD, 8'h00);
    {cmp1_sync_en, cmp2_sync_en} <= 2'b00;
    $display("comparator sync test done");
  endtask

  task automatic t_shut;
    logic [3:0] ps;
    logic [3:0] eo;
    wr(`OFS_CHCTRL, 8'h0c);
    wr(`OFS_STEER, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      ps = (i == 0) ? 4'b0001 : (i == 1) ? 4'b0100 : (i == 2) ? 4'b1001 : 4'b0010;
      eo = {~ps[1], ~ps[3], ~ps[1], ~ps[3]};
      wr(`OFS_ASD, {4'b0100, ps});
      fault_input_pin_n <= 1'b0;
      cyc(2);
      chk({oe, pv & oe}, {eo, {ps[0], ps[2], ps[0], ps[2]} & eo});
      fault_input_pin_n <= 1'b1;
      cyc(70);
      rdc(`OFS_ASD, {24'h0, 4'b1100, ps});
      wr(`OFS_ASD, {4'b0100, ps});
      cyc(3);
      chk(oe, 32'hf);
    end
    // auto restart waits for the next period start after the fault goes away
    wr(`OFS_ASD, 8'h40);
    wr(`OFS_PWMCON, 8'h80);
    fault_input_pin_n <= 1'b0;
    cyc(4);
    rdc(`OFS_ASD, 32'hc0);
    fault_input_pin_n <= 1'b1;
    cyc(70);
    rdc(`OFS_ASD, 32'h40);
    chk(oe, 32'hf);
    wr(`OFS_PWMCON, 8'h00);
    wr(`OFS_ASD, 8'h00);
    $display("shutdown test done");
  endtask

  task automatic t_delay;
    int n;
    wr(`OFS_STEER, 8'h01);
    for (int k = 0; k < 8; k = 6 * k + 1) begin
      wr(`OFS_PWMCON, k[7:0]);
      pulse;
      n = 0;
      while (pwm_out_a !== 1'b1 && n < 300) begin
        @(posedge hclk);
        n++;
      end
      chk(n, 2 + 4 * k);
      while (tb_pwm_level[0] !== 1'b0 && n < 300) begin
        @(posedge hclk);
        n++;
      end
      n = 0;
      while (pwm_out_a !== 1'b0 && n < 300) begin
        @(posedge hclk);
        n++;
      end
      chk(n, 2);
    end
    wr(`OFS_PWMCON, 8'h00);
    $display("delay test done");
  endtask

  task automatic t_steer;
    pulse;
    wr(`OFS_STEER, 8'h12);
    cyc(4);
    chk(oe, 32'h1);
    pulse;
    cyc(3);
    chk(oe, 32'h2);
    wr(`OFS_STEER, 8'h04);
    cyc(6);
    chk(oe, 32'h4);
    $display("steering test done");
  endtask

  task automatic t_pins;
    // control, steering, then expected enables and driven levels with the pwm level high
    logic [23:0] tab [9] = '{24'h0c0fff, 24'h0d0ff5, 24'h0e0ffa, 24'h0f0ff0, 24'h0c0555,
                             24'h4c01f9, 24'h8c0331, 24'hcc01f6, 24'h000f00};
    for (int i = 0; i < 9; i++) begin
      wr(`OFS_CHCTRL, tab[i][23:16]);
      wr(`OFS_STEER, tab[i][15:8]);
      pulse;
      cyc(10);
      chk({oe, pv & oe}, tab[i][7:0]);
    end
    wr(`OFS_STEER, 8'h01);
    $display("pin map test done");
  endtask

  // ****************
  // run
  // ****************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ceiling is about ten times the two thousand or so cycles the scenarios need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up;
    end
  end

  initial begin
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    t_regs;
    t_codes;
    t_sync;
    t_shut;
    t_delay;
    t_steer;
    t_pins;
    wrap_up;
  end
endmodule
